/* File: dcfpf_fifo.sv */
// dual-clock fifo with programmable almost flags and ahb-lite status port
//
// The AHB-Lite register port and the register offsets were decided locally.
`timescale 1ns/1ps
module dcfpf_fifo #(
  parameter int unsigned DEPTH = dcfpf_pkg::DEPTH_DEF,
  parameter int unsigned WIDTH = dcfpf_pkg::WIDTH_DEF
) (
  input  wire logic                                       clk,
  input  wire logic                                       rstn,
  input  wire logic                                       write_side_clock,
  input  wire logic                                       read_side_clock,
  input  wire logic                                       push_enable,
  input  wire logic                                       pop_enable,
  input  wire logic                                       write_side_reset_n,
  input  wire logic                                       read_side_reset_n,
  input  wire logic                                       threshold_load_strobe,
  input  wire logic                                       threshold_select,
  input  wire logic [dcfpf_pkg::din_w(WIDTH, DEPTH)-1:0]  data_in_bus,
  output logic      [WIDTH-1:0]                           data_out_bus,
  output logic                                            full_flag,
  output logic                                            almost_full_flag,
  output logic                                            empty_flag,
  output logic                                            almost_empty_flag,
  output logic                                            irq,
  input  wire logic                                       hsel,
  input  wire logic [31:0]                                haddr,
  input  wire logic [1:0]                                 htrans,
  input  wire logic                                       hwrite,
  input  wire logic [2:0]                                 hsize,
  input  wire logic [31:0]                                hwdata,
  input  wire logic                                       hready,
  output logic                                            hreadyout,
  output logic [31:0]                                     hrdata,
  output logic                                            hresp
);
  import dcfpf_pkg::*;

  localparam int unsigned AW    = $clog2(DEPTH);
  localparam int unsigned CW    = AW + 1;
  localparam int unsigned DIN_W = din_w(WIDTH, DEPTH);
  localparam int unsigned SYW   = SY_DIN + DIN_W;
  localparam logic [AW-1:0] AE_DEF = AW'(DEPTH / 4);
  localparam logic [AW-1:0] AF_DEF = AW'((3 * DEPTH) / 4);
  localparam logic [CW-1:0] CNT_FULL = CW'(DEPTH);

  ////////////////////////////////////////////////////////////////////////////
  // elaboration checks
  if (DEPTH < DEPTH_MIN || DEPTH > DEPTH_MAX || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
    $error("depth must be a power of two from 32 to 1024");
  end
  if (WIDTH < 1) begin : g_bad_width
    $error("word width must be at least one bit");
  end

  // occupancy from pointers carrying one wrap bit
  function automatic logic [CW-1:0] occ(input logic [CW-1:0] wp, input logic [CW-1:0] rp);
    return wp - rp;
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisation; clocks, controls and data share one delay
  logic [SYW-1:0] pin_vec;
  assign pin_vec = {data_in_bus, threshold_select, threshold_load_strobe,
                    read_side_reset_n, write_side_reset_n, pop_enable,
                    push_enable, read_side_clock, write_side_clock};

  dcfpf_sync_if #(.W(SYW)) sy_if ();

  dcfpf_sync #(.W(SYW)) u_sync (
    .clk  (clk),
    .rstn (rstn),
    .pins (pin_vec),
    .sy   (sy_if.src)
  );

  logic             wr_rise;
  logic             wr_fall;
  logic             rd_rise;
  logic             push_s;
  logic             pop_s;
  logic             wrst_n_s;
  logic             rrst_n_s;
  logic             ld_rise;
  logic             sel_s;
  logic [DIN_W-1:0] din_s;

  // named views of the synchronised pins
  assign wr_rise  = sy_if.rise[SY_WCLK];
  assign wr_fall  = sy_if.fall[SY_WCLK];
  assign rd_rise  = sy_if.rise[SY_RCLK];
  assign push_s   = sy_if.lvl[SY_PUSH];
  assign pop_s    = sy_if.lvl[SY_POP];
  assign wrst_n_s = sy_if.lvl[SY_WRST];
  assign rrst_n_s = sy_if.lvl[SY_RRST];
  assign ld_rise  = sy_if.rise[SY_LOAD];
  assign sel_s    = sy_if.lvl[SY_SEL];
  assign din_s    = sy_if.lvl[SY_DIN +: DIN_W];

  ////////////////////////////////////////////////////////////////////////////
  // storage and pointers
  logic [WIDTH-1:0] mem [DEPTH];
  logic [CW-1:0]    wr_ptr_q;
  logic [CW-1:0]    rd_ptr_q;
  logic [CW-1:0]    wr_ptr_nx;
  logic [CW-1:0]    rd_ptr_nx;
  logic [AW-1:0]    ae_thr_q;
  logic [AW-1:0]    af_thr_q;
  logic [AW-1:0]    ae_thr_nx;
  logic [WIDTH-1:0] dout_q;
  logic             full_q;
  logic             afull_q;
  logic             empty_q;
  logic             aempty_q;
  logic             wr_do;
  logic             rd_do;
  logic             wr_over;
  logic             rd_under;

  // push enable is sampled at the falling edge, stable since the writer
  // only moves it while the write clock is low
  assign wr_do    = wr_fall & push_s & wrst_n_s & ~full_q;
  assign wr_over  = wr_fall & push_s & wrst_n_s & full_q;
  assign rd_do    = rd_rise & pop_s & rrst_n_s & ~empty_q;
  assign rd_under = rd_rise & pop_s & rrst_n_s & empty_q;

  // write pointer: cleared by the write-side reset at a write clock rise
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_ptr_q <= '0;
    end else if (wr_rise && !wrst_n_s) begin
      wr_ptr_q <= '0;
    end else if (wr_do) begin
      wr_ptr_q <= wr_ptr_q + CW'(1);
    end
  end

  // word store; a discarded push leaves the array untouched
  always_ff @(posedge clk) begin
    if (wr_do) begin
      mem[wr_ptr_q[AW-1:0]] <= din_s[WIDTH-1:0];
    end
  end

  // read pointer: a read-side reset rewinds to the first word written
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rd_ptr_q <= '0;
    end else if (rd_rise && !rrst_n_s) begin
      rd_ptr_q <= '0;
    end else if (rd_do) begin
      rd_ptr_q <= rd_ptr_q + CW'(1);
    end
  end

  // output word changes only at the read clock rise of a pop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      dout_q <= '0;
    end else if (rd_do) begin
      dout_q <= mem[rd_ptr_q[AW-1:0]];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // thresholds
  always_ff @(posedge clk) begin
    if (!rstn) begin
      ae_thr_q <= AE_DEF;
    end else if (rd_rise && !rrst_n_s) begin
      ae_thr_q <= AE_DEF;
    end else if (ld_rise && !sel_s) begin
      ae_thr_q <= din_s[AW-1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      af_thr_q <= AF_DEF;
    end else if (ld_rise && sel_s) begin
      af_thr_q <= din_s[AW-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // flag evaluation on pointers as they will stand after this edge
  logic [CW-1:0] cnt_w;
  logic [CW-1:0] cnt_r;
  logic          full_nx;
  logic          afull_nx;
  logic          empty_nx;
  logic          aempty_nx;

  always_comb begin
    wr_ptr_nx = wrst_n_s ? wr_ptr_q : '0;
    rd_ptr_nx = !rrst_n_s ? '0 : (rd_do ? rd_ptr_q + CW'(1) : rd_ptr_q);
    ae_thr_nx = rrst_n_s ? ae_thr_q : AE_DEF;
    cnt_w     = occ(wr_ptr_nx, rd_ptr_q);
    cnt_r     = occ(wr_ptr_q, rd_ptr_nx);
    full_nx   = (cnt_w == CNT_FULL);
    afull_nx  = (cnt_w >= {1'b0, af_thr_q});
    empty_nx  = (cnt_r == '0);
    aempty_nx = (cnt_r <= {1'b0, ae_thr_nx});
  end

  // full side flags move only at write clock rises
  always_ff @(posedge clk) begin
    if (!rstn) begin
      full_q  <= 1'b0;
      afull_q <= 1'b0;
    end else if (wr_rise) begin
      full_q  <= full_nx;
      afull_q <= afull_nx;
    end
  end

  // empty side flags move only at read clock rises
  always_ff @(posedge clk) begin
    if (!rstn) begin
      empty_q  <= 1'b1;
      aempty_q <= 1'b1;
    end else if (rd_rise) begin
      empty_q  <= empty_nx;
      aempty_q <= aempty_nx;
    end
  end

  assign data_out_bus      = dout_q;
  assign full_flag         = full_q;
  assign almost_full_flag  = afull_q;
  assign empty_flag        = empty_q;
  assign almost_empty_flag = aempty_q;

  ////////////////////////////////////////////////////////////////////////////
  // interrupt status, mask and output
  logic [ST_BITS-1:0] status_q;
  logic [ST_BITS-1:0] mask_q;
  logic [ST_BITS-1:0] st_set;
  logic [ST_BITS-1:0] st_clr;
  logic               irq_q;
  logic               wr_st_q;
  logic               wr_mk_q;

  // events: a flag rising, a refused push or a refused pop
  always_comb begin
    st_set            = '0;
    st_set[ST_FULL]   = wr_rise & full_nx & ~full_q;
    st_set[ST_AFULL]  = wr_rise & afull_nx & ~afull_q;
    st_set[ST_EMPTY]  = rd_rise & empty_nx & ~empty_q;
    st_set[ST_AEMPTY] = rd_rise & aempty_nx & ~aempty_q;
    st_set[ST_OVER]   = wr_over;
    st_set[ST_UNDER]  = rd_under;
  end

  assign st_clr = wr_st_q ? hwdata[ST_BITS-1:0] : '0;

  // sticky bits, write one to clear; a same-cycle event wins
  always_ff @(posedge clk) begin
    if (!rstn) begin
      status_q <= STATUS_RST;
    end else begin
      status_q <= (status_q & ~st_clr) | st_set;
    end
  end

  always_ff @(posedge clk) begin
    if (!rstn) begin
      mask_q <= MASK_RST;
    end else if (wr_mk_q) begin
      mask_q <= hwdata[ST_BITS-1:0];
    end
  end

  // level interrupt while any unmasked bit is set
  always_ff @(posedge clk) begin
    if (!rstn) begin
      irq_q <= 1'b0;
    end else begin
      irq_q <= |(status_q & mask_q);
    end
  end

  assign irq = irq_q;

  ////////////////////////////////////////////////////////////////////////////
  // ahb-lite slave, zero wait states, always okay
  logic        acc;
  logic        map_ok;
  logic [31:0] rd_val;
  logic [31:0] hrdata_q;
  logic        hready_q;
  logic        hresp_q;

  assign acc    = hsel & hready & (htrans == HTRANS_NONSEQ);
  assign map_ok = (haddr[31:AHB_AW] == '0);

  // read multiplexer; unmapped offsets read zero
  always_comb begin
    rd_val = '0;
    if (map_ok) begin
      case (haddr[AHB_AW-1:0])
        REG_STATUS: rd_val[ST_BITS-1:0] = status_q;
        REG_MASK:   rd_val[ST_BITS-1:0] = mask_q;
        REG_LEVEL: begin
          rd_val[CW-1:0]         = occ(wr_ptr_q, rd_ptr_q);
          rd_val[LV_FLAGS +: 4]  = {aempty_q, empty_q, afull_q, full_q};
        end
        default:    rd_val = '0;
      endcase
    end
  end

  // address phase: latch write targets, register read data
  always_ff @(posedge clk) begin
    if (!rstn) begin
      wr_st_q  <= 1'b0;
      wr_mk_q  <= 1'b0;
      hrdata_q <= '0;
    end else begin
      wr_st_q <= acc & hwrite & (hsize == HSIZE_WORD) & map_ok &
                 (haddr[AHB_AW-1:0] == REG_STATUS);
      wr_mk_q <= acc & hwrite & (hsize == HSIZE_WORD) & map_ok &
                 (haddr[AHB_AW-1:0] == REG_MASK);
      if (acc && !hwrite) begin
        hrdata_q <= rd_val;
      end
    end
  end

  // ready and response stand constant after reset
  always_ff @(posedge clk) begin
    if (!rstn) begin
      hready_q <= 1'b1;
      hresp_q  <= HRESP_OKAY;
    end else begin
      hready_q <= 1'b1;
      hresp_q  <= HRESP_OKAY;
    end
  end

  assign hreadyout = hready_q;
  assign hrdata    = hrdata_q;
  assign hresp     = hresp_q;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rstn);

  AST_PUSH_STORES:
    assert property (wr_fall && push_s && wrst_n_s && !full_q
                     |=> wr_ptr_q == $past(wr_ptr_q) + CW'(1))
    else $error("accepted push did not advance the write pointer");

  AST_POP_PRESENTS:
    assert property (rd_do |=> rd_ptr_q == $past(rd_ptr_q) + CW'(1)
                     && dout_q == $past(mem[rd_ptr_q[AW-1:0]]))
    else $error("pop did not present the stored word and advance");

  AST_LOAD_THRESHOLDS:
    assert property (ld_rise && rrst_n_s |=> ($past(sel_s) ? af_thr_q : ae_thr_q)
                     == $past(din_s[AW-1:0]))
    else $error("threshold strobe did not load the selected threshold");

  AST_RESET_DEFAULTS:
    assert property ($rose(rstn) |-> ae_thr_q == AE_DEF && af_thr_q == AF_DEF)
    else $error("thresholds not at quarter and three quarter depth");

  AST_FULL_ON_WCLK:
    assert property (!wr_rise |=> $stable(full_q) && $stable(afull_q))
    else $error("full side flags changed away from a write clock rise");

  AST_EMPTY_ON_RCLK:
    assert property (!rd_rise |=> $stable(empty_q) && $stable(aempty_q))
    else $error("empty side flags changed away from a read clock rise");

  AST_WRITE_RESET:
    assert property (wr_rise && !wrst_n_s |=> wr_ptr_q == '0)
    else $error("write-side reset did not clear the write pointer");

  AST_READ_RESET:
    assert property (rd_rise && !rrst_n_s |=> rd_ptr_q == '0 && ae_thr_q == AE_DEF
                     && empty_q == ($past(wr_ptr_q) == '0))
    else $error("read-side reset did not rewind and restore the threshold");

  AST_REFUSED_PUSH:
    assert property (wr_over |=> $stable(wr_ptr_q) && status_q[ST_OVER])
    else $error("push while full moved the write pointer");

  AST_ALMOST_EMPTY:
    assert property (rd_rise && rrst_n_s && !rd_do
                     |=> aempty_q == (occ($past(wr_ptr_q), rd_ptr_q) <= {1'b0, ae_thr_q}))
    else $error("almost empty flag disagrees with count and threshold");

endmodule // dcfpf_fifo

/* File: dcfpf_pkg.sv */
// shared constants for the dual-clock programmable-flag fifo
package dcfpf_pkg;

  // depth and width limits and defaults
  localparam int unsigned DEPTH_DEF = 32;
  localparam int unsigned DEPTH_MIN = 32;
  localparam int unsigned DEPTH_MAX = 1024;
  localparam int unsigned WIDTH_DEF = 8;

  // bit positions inside the synchronised pin vector
  localparam int unsigned SY_WCLK = 0;
  localparam int unsigned SY_RCLK = 1;
  localparam int unsigned SY_PUSH = 2;
  localparam int unsigned SY_POP  = 3;
  localparam int unsigned SY_WRST = 4;
  localparam int unsigned SY_RRST = 5;
  localparam int unsigned SY_LOAD = 6;
  localparam int unsigned SY_SEL  = 7;
  localparam int unsigned SY_DIN  = 8;

  // register map, byte addresses
  localparam int unsigned AHB_AW     = 12;
  localparam logic [11:0] REG_STATUS = 12'h000;
  localparam logic [11:0] REG_MASK   = 12'h004;
  localparam logic [11:0] REG_LEVEL  = 12'h008;

  // status and mask bit positions
  localparam int unsigned ST_FULL   = 0;
  localparam int unsigned ST_AFULL  = 1;
  localparam int unsigned ST_EMPTY  = 2;
  localparam int unsigned ST_AEMPTY = 3;
  localparam int unsigned ST_OVER   = 4;
  localparam int unsigned ST_UNDER  = 5;
  localparam int unsigned ST_BITS   = 6;
  localparam logic [5:0]  STATUS_RST = 6'h00;
  localparam logic [5:0]  MASK_RST   = 6'h00;

  // level register: flags above the occupancy count
  localparam int unsigned LV_FLAGS = 16;

  // bus encodings
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [2:0] HSIZE_WORD    = 3'h2;
  localparam logic       HRESP_OKAY    = 1'h0;

  // width of the input bus: word width or log2 depth, whichever is larger
  function automatic int unsigned din_w(int unsigned w, int unsigned d);
    return (w > $clog2(d)) ? w : $clog2(d);
  endfunction

endpackage

/* File: dcfpf_sync_if.sv */
// synchronised pin levels and their edges, passed from the synchroniser
`timescale 1ns/1ps
interface dcfpf_sync_if #(parameter int unsigned W = 1);
  logic [W-1:0] lvl;
  logic [W-1:0] rise;
  logic [W-1:0] fall;
  modport src (output lvl, output rise, output fall);
  modport dst (input lvl, input rise, input fall);
endinterface

/* File: dcfpf_sync.sv */
// two-flop synchroniser with edge detection for the fifo pins
`timescale 1ns/1ps
module dcfpf_sync #(
  parameter int unsigned W = 1
) (
  input  wire logic         clk,
  input  wire logic         rstn,
  input  wire logic [W-1:0] pins,
  dcfpf_sync_if.src         sy
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // s1 feeds only s2; edges are taken between s2 and s3
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // level and one-cycle edge pulses
  assign sy.lvl  = s2_q;
  assign sy.rise = s2_q & ~s3_q;
  assign sy.fall = ~s2_q & s3_q;

endmodule // dcfpf_sync

/* File: dcfpf_partner.sv */
// pin-side producer and consumer model for the fifo
`timescale 1ns/1ps
module dcfpf_partner #(
  parameter int unsigned DW = 8
) (
  input  wire logic     clk,
  output logic          write_side_clock,
  output logic          read_side_clock,
  output logic          push_enable,
  output logic          pop_enable,
  output logic          write_side_reset_n,
  output logic          read_side_reset_n,
  output logic          threshold_load_strobe,
  output logic          threshold_select,
  output logic [DW-1:0] data_in_bus
);
  ////////////////////////////////////////////////////////////////////////////
  // quiet pins at time zero, side resets released
  initial begin
    write_side_clock = 1'b0;
    read_side_clock = 1'b0;
    push_enable = 1'b0;
    pop_enable = 1'b0;
    write_side_reset_n = 1'b1;
    read_side_reset_n = 1'b1;
    threshold_load_strobe = 1'b0;
    threshold_select = 1'b0;
    data_in_bus = '0;
  end

  // wait whole system clocks
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask

  // enable and word settle while the write clock is low, then it rises
  task automatic wr_rise(input logic en, input logic [DW-1:0] d);
    push_enable <= en;
    data_in_bus <= d;
    tick(2);
    write_side_clock <= 1'b1;
    tick(6);
  endtask

  // falling edge stores the word; the bus is scrambled once hold is over
  task automatic wr_fall();
    write_side_clock <= 1'b0;
    tick(2);
    data_in_bus <= ~data_in_bus;
    tick(1);
  endtask

  // one write clock period with the write-side reset held low across the rise
  task automatic wr_rst();
    push_enable <= 1'b0;
    write_side_reset_n <= 1'b0;
    tick(2);
    write_side_clock <= 1'b1;
    tick(6);
    write_side_clock <= 1'b0;
    tick(2);
    write_side_reset_n <= 1'b1;
    tick(1);
  endtask

  // read clock rise, optionally with the read-side reset held low across it
  task automatic rd_rise(input logic en, input logic rst);
    pop_enable <= en;
    read_side_reset_n <= ~rst;
    tick(2);
    read_side_clock <= 1'b1;
    tick(6);
  endtask

  // read clock falls, reset released only after the rise has passed
  task automatic rd_fall();
    read_side_clock <= 1'b0;
    tick(2);
    read_side_reset_n <= 1'b1;
    tick(1);
  endtask

  // strobe a value into the threshold picked by select
  task automatic thr_load(input logic sel, input logic [DW-1:0] v);
    threshold_select <= sel;
    data_in_bus <= v;
    tick(2);
    threshold_load_strobe <= 1'b1;
    tick(3);
    threshold_load_strobe <= 1'b0;
    tick(2);
    data_in_bus <= ~v;
    tick(1);
  endtask
endmodule // dcfpf_partner

/* File: dcfpf_fifo_bench.sv */
// self-checking bench for the dual-clock programmable-flag fifo
`timescale 1ns/1ps
`define CHK(act, exp) chk(32'(act), 32'(exp))
module dcfpf_fifo_bench;
  import dcfpf_pkg::*;
  localparam int DEPTH = 32;
  localparam int WIDTH = 8;
  localparam int DW = din_w(WIDTH, DEPTH);
  logic             clk, rstn, hsel, hwrite, hready, hreadyout, hresp, irq;
  logic [31:0]      haddr, hwdata, hrdata, seed, rd_v;
  logic [1:0]       htrans;
  logic [2:0]       hsize;
  logic             wclk, rclk, push_en, pop_en, wrst_n, rrst_n, strobe, sel;
  logic [DW-1:0]    din;
  logic [WIDTH-1:0] dout, last;
  logic             full_flag, almost_full_flag, empty_flag, almost_empty_flag;
  logic [WIDTH-1:0] wq[$];
  logic [5:0]       st;
  logic [3:0]       fl;
  int               rd_n, ae_t, af_t;
  int unsigned      n_mismatch, total_checks;

  assign hready = hreadyout;

  ////////////////////////////////////////////////////////////////////////////
  // clock
  always #25 clk = ~clk;

  dcfpf_partner #(.DW(DW)) dcfpf_partner_i (
    .clk(clk), .write_side_clock(wclk), .read_side_clock(rclk),
    .push_enable(push_en), .pop_enable(pop_en), .write_side_reset_n(wrst_n),
    .read_side_reset_n(rrst_n), .threshold_load_strobe(strobe),
    .threshold_select(sel), .data_in_bus(din));

  dcfpf_fifo #(.DEPTH(DEPTH), .WIDTH(WIDTH)) dcfpf_fifo_i (
    .clk(clk), .rstn(rstn), .write_side_clock(wclk), .read_side_clock(rclk),
    .push_enable(push_en), .pop_enable(pop_en), .write_side_reset_n(wrst_n),
    .read_side_reset_n(rrst_n), .threshold_load_strobe(strobe),
    .threshold_select(sel), .data_in_bus(din), .data_out_bus(dout),
    .full_flag(full_flag), .almost_full_flag(almost_full_flag),
    .empty_flag(empty_flag), .almost_empty_flag(almost_empty_flag), .irq(irq),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hreadyout(hreadyout), .hrdata(hrdata),
    .hresp(hresp));

  ////////////////////////////////////////////////////////////////////////////
  // xorshift source for data words
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  // compare and count
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    total_checks++;
    if (act !== exp) begin
      n_mismatch++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, act, exp);
    end
  endtask

  // verdict and end of run
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // model flag update, a rising flag sets its sticky status bit
  task automatic setfl(input int i, input logic v);
    if (v && !fl[i]) st[i] = 1'b1;
    fl[i] = v;
  endtask

  // one ahb-lite single word transfer, waits on hready in both phases
  task automatic ahb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= HTRANS_NONSEQ;
    hwrite <= wr;
    hsize <= HSIZE_WORD;
    do @(posedge clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd_v = hrdata;
    `CHK(hresp, HRESP_OKAY);
  endtask

  // register read with comparison
  task automatic rchk(input logic [11:0] a, input logic [31:0] exp);
    ahb(1'b0, a, 32'h0);
    `CHK(rd_v, exp);
  endtask

  // irq level a few clocks after a register change
  task automatic irq_is(input logic exp);
    repeat (3) @(posedge clk);
    `CHK(irq, exp);
  endtask

  // one write clock period; flags reflect the count before this push
  task automatic push(input logic en);
    logic [WIDTH-1:0] d;
    int cnt;
    d = WIDTH'(rnd());
    cnt = wq.size() - rd_n;
    dcfpf_partner_i.wr_rise(en, DW'(d));
    setfl(0, cnt >= DEPTH);
    setfl(1, cnt >= af_t);
    `CHK(full_flag, fl[0]);
    `CHK(almost_full_flag, fl[1]);
    dcfpf_partner_i.wr_fall();
    if (en && cnt >= DEPTH) st[4] = 1'b1;
    else if (en) wq.push_back(d);
  endtask

  // one read clock period, optionally a read-side reset
  task automatic pop(input logic en, input logic rst);
    int cnt;
    if (rst) begin
      rd_n = 0;
      ae_t = DEPTH / 4;
    end else if (en && !fl[2]) begin
      last = wq[rd_n];
      rd_n++;
    end else if (en) st[5] = 1'b1;
    cnt = wq.size() - rd_n;
    setfl(2, cnt == 0);
    setfl(3, cnt <= ae_t);
    dcfpf_partner_i.rd_rise(en, rst);
    `CHK(dout, last);
    `CHK(empty_flag, fl[2]);
    `CHK(almost_empty_flag, fl[3]);
    dcfpf_partner_i.rd_fall();
  endtask

  // general reset, model cleared, outputs and registers checked
  task automatic do_reset();
    rstn <= 1'b0;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    repeat (5) @(posedge clk);
    wq.delete();
    rd_n = 0;
    ae_t = DEPTH / 4;
    af_t = DEPTH * 3 / 4;
    last = '0;
    st = '0;
    fl = 4'b1100;
    `CHK({almost_empty_flag, empty_flag, almost_full_flag, full_flag}, fl);
    `CHK({dout, irq, hreadyout}, 10'h001);
    rchk(REG_STATUS, 32'h0);
    rchk(REG_MASK, 32'h0);
    rchk(12'h00C, 32'h0);
  endtask

  ////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    {hsel, hwrite, haddr, htrans, hsize, hwdata} = '0;
    n_mismatch = 0;
    total_checks = 0;
    seed = 32'd58303;
    @(posedge clk);
    do_reset();
    // retransmit with both thresholds loaded
    dcfpf_partner_i.thr_load(1'b1, DW'(3));
    af_t = 3;
    for (int i = 0; i < 6; i++) push(1'b1);
    push(1'b0);
    dcfpf_partner_i.thr_load(1'b0, DW'(2));
    ae_t = 2;
    pop(1'b0, 1'b0);
    for (int i = 0; i < 4; i++) pop(1'b1, 1'b0);
    pop(1'b0, 1'b1);
    for (int i = 0; i < 7; i++) pop(1'b1, 1'b0);
    rchk(REG_LEVEL, {12'h0, fl, 16'(wq.size() - rd_n)});
    // read then write side reset empties the buffer, which then runs on
    pop(1'b0, 1'b1);
    dcfpf_partner_i.wr_rst();
    wq.delete();
    rd_n = 0;
    push(1'b1);
    pop(1'b0, 1'b0);
    pop(1'b1, 1'b0);
    rchk(REG_LEVEL, {12'h0, fl, 16'(wq.size() - rd_n)});
    // second general reset, then fill past full and drain past empty
    do_reset();
    for (int i = 0; i <= DEPTH + 1; i++) push(1'b1);
    rchk(REG_LEVEL, {12'h0, fl, 16'(wq.size() - rd_n)});
    for (int i = 0; i <= DEPTH; i++) pop(1'b1, 1'b0);
    // status, mask and irq
    rchk(REG_STATUS, 32'(st));
    ahb(1'b1, REG_MASK, 32'h30);
    irq_is(1'b1);
    ahb(1'b1, REG_STATUS, 32'h10);
    st[4] = 1'b0;
    irq_is(1'b1);
    ahb(1'b1, REG_STATUS, 32'h20);
    st[5] = 1'b0;
    irq_is(1'b0);
    ahb(1'b1, REG_MASK, 32'h01);
    irq_is(st[0]);
    ahb(1'b1, REG_STATUS, 32'h0F);
    st[3:0] = 4'h0;
    irq_is(1'b0);
    rchk(REG_STATUS, 32'(st));
    rchk(REG_MASK, 32'h01);
    ahb(1'b1, 12'h00C, 32'hFFFF_FFFF);
    rchk(12'h00C, 32'h0);
    end_of_test();
  end

  // watchdog against a hang
  initial begin
    #(50 * 20000);
    n_mismatch++;
    end_of_test();
  end
endmodule // dcfpf_fifo_bench
